/* pdc_pkg.sv */
// package: register map, reset values and pin carriers for the port direction block
package pdc_pkg;

  // ---------------------------------------------------------------------------
  // register map (printed offsets are word indices; byte address = index * 4)
  // ---------------------------------------------------------------------------
  localparam int NUM_DIR = 13;
  localparam int NUM_OWN = 6;
  localparam int IDX_W = 20;
  localparam int DIR_P4 = 4;
  localparam int DIR_P5 = 5;

  localparam logic [IDX_W-1:0] DIR_IDX [NUM_DIR] = '{
    20'hFFF20, 20'hFFF21, 20'hFFF22, 20'hFFF23, 20'hFFF24, 20'hFFF25, 20'hFFF26,
    20'hFFF27, 20'hFFF29, 20'hFFF2B, 20'hFFF2C, 20'hFFF2E, 20'hFFF2F};

  // writable direction bits; every other bit is fixed at one
  localparam logic [7:0] DIR_WMASK [NUM_DIR] = '{
    8'h7C, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h3F, 8'hFF,
    8'hFF, 8'h03, 8'h03, 8'h01, 8'h1D, 8'h0F};

  // port data latches, pull-up options and control mode selects
  localparam int OWN_DATA4 = 0;
  localparam int OWN_DATA5 = 1;
  localparam int OWN_PU4 = 2;
  localparam int OWN_PU5 = 3;
  localparam int OWN_CTRL4 = 4;
  localparam int OWN_CTRL5 = 5;
  localparam logic [IDX_W-1:0] OWN_IDX [NUM_OWN] = '{
    20'hFFF04, 20'hFFF05, 20'hFFF34, 20'hFFF35, 20'hFFF44, 20'hFFF45};

  // ---------------------------------------------------------------------------
  // reset values and pin masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] P4_PIN_MASK = 8'hFF;
  localparam logic [7:0] P5_PIN_MASK = 8'h3F;
  localparam logic [9:0] ADDR_TOP_ZERO = 10'h000;
  localparam logic [23:0] RDATA_PAD = 24'h000000;

  // ---------------------------------------------------------------------------
  // bus and pin carriers
  // ---------------------------------------------------------------------------
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pdc_pin_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pdc_alt_s;

endpackage

/* pdc_port_dir.sv */
// port 4 / port 5 direction, pull-up and control-mode logic with an AHB-Lite register slave
//
// Functional notes
// - each pin selectable: port mode or peripheral control
// - direction one: input, buffer off; zero: drive latch
// - port 5 has latch and per-bit direction
// - pull-up enable only for input port pins
// - reset sets all direction registers to all ones
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps

module pdc_port_dir (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pin levels
  input wire logic [7:0] p4_pin_in,
  input wire logic [7:0] p5_pin_in,
  // peripheral drive for control mode
  input wire pdc_pkg::pdc_alt_s p4_alt,
  input wire pdc_pkg::pdc_alt_s p5_alt,
  // pin drive
  output pdc_pkg::pdc_pin_s p4_pins,
  output pdc_pkg::pdc_pin_s p5_pins
);
  import pdc_pkg::*;

  // ---------------------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic idx_hit(input logic [31:0] addr, input logic [IDX_W-1:0] idx);
    idx_hit = (addr[31:22] == ADDR_TOP_ZERO) && (addr[21:2] == idx);
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] pin,
                                           input logic [7:0] latch);
    port_read = (dir & pin) | (~dir & latch);
  endfunction

  // ---------------------------------------------------------------------------
  // bus pipeline: address phase captured, write applied in data phase
  // ---------------------------------------------------------------------------
  logic wr_pend_ff, nxt_wr_pend;
  logic [31:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;
  logic req;
  logic [7:0] dir_q [NUM_DIR];
  logic [7:0] nxt_dir [NUM_DIR];
  logic [7:0] own_q [NUM_OWN];
  logic [7:0] nxt_own [NUM_OWN];

  // hsize is not checked: only whole-word single transfers are issued
  assign req = hsel && hready && htrans[1];

  always_comb begin
    nxt_wr_pend = req && hwrite;
    nxt_wr_addr = req ? haddr : wr_addr_ff;
    nxt_hrdata = hrdata_ff;
    if (req && !hwrite) begin
      // read from next values so a read right behind a write sees the new data
      nxt_hrdata = 32'h00000000;
      for (int i = 0; i < NUM_DIR; i++) begin
        if (idx_hit(haddr, DIR_IDX[i])) begin
          nxt_hrdata = {RDATA_PAD, nxt_dir[i]};
        end
      end
      for (int j = 0; j < NUM_OWN; j++) begin
        if (idx_hit(haddr, OWN_IDX[j])) begin
          nxt_hrdata = {RDATA_PAD, nxt_own[j]};
        end
      end
      if (idx_hit(haddr, OWN_IDX[OWN_DATA4])) begin
        nxt_hrdata = {RDATA_PAD, port_read(nxt_dir[DIR_P4], p4_pin_in,
                                           nxt_own[OWN_DATA4])};
      end
      if (idx_hit(haddr, OWN_IDX[OWN_DATA5])) begin
        nxt_hrdata = {RDATA_PAD, port_read(nxt_dir[DIR_P5], p5_pin_in & P5_PIN_MASK,
                                           nxt_own[OWN_DATA5]) & P5_PIN_MASK};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h00000000;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= HRESP_OKAY;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ---------------------------------------------------------------------------
  // direction registers; unimplemented bits stay one whatever is written
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < NUM_DIR; g++) begin : g_dir
    logic [7:0] q_ff;
    always_comb begin
      nxt_dir[g] = q_ff;
      if (wr_pend_ff && idx_hit(wr_addr_ff, DIR_IDX[g])) begin
        nxt_dir[g] = (hwdata[7:0] & DIR_WMASK[g]) | ~DIR_WMASK[g];
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        q_ff <= DIR_RESET;
      end else begin
        q_ff <= nxt_dir[g];
      end
    end
    assign dir_q[g] = q_ff;
  end

  // ---------------------------------------------------------------------------
  // data latches, pull-up options, control mode selects
  // ---------------------------------------------------------------------------
  for (genvar k = 0; k < NUM_OWN; k++) begin : g_own
    logic [7:0] q_ff;
    always_comb begin
      nxt_own[k] = q_ff;
      if (wr_pend_ff && idx_hit(wr_addr_ff, OWN_IDX[k])) begin
        nxt_own[k] = hwdata[7:0];
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        q_ff <= OWN_RESET;
      end else begin
        q_ff <= nxt_own[k];
      end
    end
    assign own_q[k] = q_ff;
  end

  // ---------------------------------------------------------------------------
  // pin drive, registered so the pads see no decode glitches
  // ---------------------------------------------------------------------------
  pdc_pin_s p4_ff, nxt_p4;
  pdc_pin_s p5_ff, nxt_p5;
  logic [7:0] dir4, dir5, ctl4, ctl5;

  assign dir4 = dir_q[DIR_P4];
  assign dir5 = dir_q[DIR_P5];
  assign ctl4 = own_q[OWN_CTRL4];
  assign ctl5 = own_q[OWN_CTRL5];

  always_comb begin
    // control mode hands the pin to the peripheral bit by bit
    nxt_p4.out = (ctl4 & p4_alt.out) | (~ctl4 & own_q[OWN_DATA4]);
    nxt_p4.oe = (ctl4 & p4_alt.oe) | (~ctl4 & ~dir4);
    nxt_p4.pu = own_q[OWN_PU4] & dir4 & ~ctl4 & P4_PIN_MASK;
    // port 5 bits 6 and 7 have no pad and are never driven
    nxt_p5.out = ((ctl5 & p5_alt.out) | (~ctl5 & own_q[OWN_DATA5])) & P5_PIN_MASK;
    nxt_p5.oe = ((ctl5 & p5_alt.oe) | (~ctl5 & ~dir5)) & P5_PIN_MASK;
    nxt_p5.pu = own_q[OWN_PU5] & dir5 & ~ctl5 & P5_PIN_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p4_ff <= '0;
      p5_ff <= '0;
    end else begin
      p4_ff <= nxt_p4;
      p5_ff <= nxt_p5;
    end
  end

  assign p4_pins = p4_ff;
  assign p5_pins = p5_ff;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_dir5;
    req && hwrite && idx_hit(haddr, DIR_IDX[DIR_P5]);
  endsequence

  sequence s_rd_data4;
    req && !hwrite && idx_hit(haddr, OWN_IDX[OWN_DATA4]) && !wr_pend_ff;
  endsequence

  a_input_buffer_off: assert property (
    ((dir4 & ~ctl4) != 8'h00) |=> ((p4_pins.oe & $past(dir4 & ~ctl4)) == 8'h00))
    else $error("port 4 input pin still drives");

  a_output_drives_latch: assert property (
    ((~dir4 & ~ctl4) != 8'h00) |=>
      ((p4_pins.oe & $past(~dir4 & ~ctl4)) == $past(~dir4 & ~ctl4)) &&
      ((p4_pins.out & $past(~dir4 & ~ctl4)) == ($past(own_q[OWN_DATA4]) & $past(~dir4 & ~ctl4))))
    else $error("port 4 output pin not driving latch");

  a_ctrl_hands_over: assert property (
    (ctl5 != 8'h00) |=>
      ((p5_pins.oe & $past(ctl5)) == ($past(p5_alt.oe) & $past(ctl5) & P5_PIN_MASK)))
    else $error("control mode pin not following peripheral");

  a_pullup_input_only: assert property (
    ##1 ((p4_pins.pu & ~$past(dir4 & ~ctl4)) == 8'h00) &&
        ((p5_pins.pu & ~$past(dir5 & ~ctl5)) == 8'h00))
    else $error("pull-up on a pin that is not an input port");

  a_dir5_write: assert property (
    s_wr_dir5 ##1 wr_pend_ff |=>
      dir5 == (($past(hwdata[7:0]) & DIR_WMASK[DIR_P5]) | ~DIR_WMASK[DIR_P5]))
    else $error("port 5 direction write not stored");

  a_reset_dirs_ones: assert property (
    $rose(hresetn) |-> (dir5 == DIR_RESET) && (dir4 == DIR_RESET) && (p5_pins.oe == 8'h00))
    else $error("direction registers not all ones after reset");

  a_fixed_bits_one: assert property (
    (dir5 | DIR_WMASK[DIR_P5]) == 8'hFF)
    else $error("unimplemented port 5 direction bit cleared");

  a_read_port_data: assert property (
    s_rd_data4 |=>
      hrdata == {RDATA_PAD, port_read($past(dir4), $past(p4_pin_in), $past(own_q[OWN_DATA4]))})
    else $error("port 4 data read mixes pin and latch wrongly");

  // ---------------------------------------------------------------------------
  // port 5, port 4 control mode, pull-up option, port 4 write and port 0 fixed-bit checks
  // ---------------------------------------------------------------------------
  // port 5 has only six pads, so its output, control and read checks mask the two missing bits off
  sequence s_wr_dir4;
    req && hwrite && idx_hit(haddr, DIR_IDX[DIR_P4]);
  endsequence

  sequence s_rd_data5;
    req && !hwrite && idx_hit(haddr, OWN_IDX[OWN_DATA5]) && !wr_pend_ff;
  endsequence

  logic [7:0] drive5_sel;
  assign drive5_sel = ~dir5 & ~ctl5 & P5_PIN_MASK;

  a_p5_input_off: assert property (
    ((dir5 & ~ctl5) != 8'h00) |=> ((p5_pins.oe & $past(dir5 & ~ctl5)) == 8'h00))
    else $error("port 5 input pin still drives");

  a_p5_output_latch: assert property (
    (drive5_sel != 8'h00) |=>
      ((p5_pins.oe & $past(drive5_sel)) == $past(drive5_sel)) &&
      ((p5_pins.out & $past(drive5_sel)) == ($past(own_q[OWN_DATA5]) & $past(drive5_sel))))
    else $error("port 5 output pin not driving latch");

  a_p5_pads_idle: assert property (
    ((p5_pins.out | p5_pins.oe | p5_pins.pu) & ~P5_PIN_MASK) == 8'h00)
    else $error("missing port 5 pad is driven");

  a_p4_ctrl_follows: assert property (
    (ctl4 != 8'h00) |=>
      ((p4_pins.oe & $past(ctl4)) == ($past(p4_alt.oe) & $past(ctl4))) &&
      ((p4_pins.out & $past(ctl4)) == ($past(p4_alt.out) & $past(ctl4))))
    else $error("port 4 control mode pin not following peripheral");

  a_p5_ctrl_out: assert property (
    (ctl5 != 8'h00) |=>
      ((p5_pins.out & $past(ctl5)) == ($past(p5_alt.out) & $past(ctl5) & P5_PIN_MASK)))
    else $error("port 5 control mode output not following peripheral");

  a_pullup_option: assert property (
    ##1 (p4_pins.pu == $past(own_q[OWN_PU4] & dir4 & ~ctl4)) &&
        (p5_pins.pu == $past(own_q[OWN_PU5] & dir5 & ~ctl5 & P5_PIN_MASK)))
    else $error("pull-up does not follow its option bit");

  a_dir4_write: assert property (
    s_wr_dir4 ##1 wr_pend_ff |=>
      dir4 == (($past(hwdata[7:0]) & DIR_WMASK[DIR_P4]) | ~DIR_WMASK[DIR_P4]))
    else $error("port 4 direction write not stored");

  a_p0_fixed_bits: assert property (
    (dir_q[0] | DIR_WMASK[0]) == 8'hFF)
    else $error("unimplemented port 0 direction bit cleared");

  a_read_port5_data: assert property (
    s_rd_data5 |=>
      hrdata == {RDATA_PAD, port_read($past(dir5), $past(p5_pin_in), $past(own_q[OWN_DATA5]))
                            & P5_PIN_MASK})
    else $error("port 5 data read mixes pin and latch wrongly");

endmodule

/* pdc_board.sv */
// board model: resolves the level on each port pin
`timescale 1ns/1ps
module pdc_board
  import pdc_pkg::*;
(
  // device drive
  input wire pdc_pkg::pdc_pin_s pins,
  // board drive
  input wire logic [7:0] drv,
  input wire logic [7:0] ext,
  // level seen by the device
  output logic [7:0] lvl
);
  // a floating pin without pull-up shows the inverse latch, so no stale level passes
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (pins.oe[b]) lvl[b] = pins.out[b];
      else if (drv[b]) lvl[b] = ext[b];
      else lvl[b] = pins.pu[b] | ~pins.out[b];
    end
  end
endmodule

/* tb_port_direction_control.sv */
// self-checking bench for the port 4 / port 5 direction block
`timescale 1ns/1ps
module tb_port_direction_control;
  import pdc_pkg::*;
  typedef struct packed {
    logic q;
    logic [7:0] dir, dat, pu, ctl, drv, ext, eo, ev, ep, er;
  } pdc_row_s;
  // ---------------------------------------------------------------------------
  // rows: port, dir, data, pull-up, ctrl, board drive/level, oe, out&oe, pu, read
  // ---------------------------------------------------------------------------
  localparam pdc_row_s ROWS [6] = '{
    '{1'b0, 8'h00, 8'h3C, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h3C, 8'h00, 8'h3C},
    '{1'b0, 8'hFF, 8'h3C, 8'hF0, 8'h00, 8'h0F, 8'h5A, 8'h00, 8'h00, 8'hF0, 8'hFA},
    '{1'b0, 8'h0F, 8'h3C, 8'hFF, 8'h00, 8'hFF, 8'h5A, 8'hF0, 8'h30, 8'h0F, 8'h3A},
    '{1'b0, 8'h0F, 8'h3C, 8'hFF, 8'hF0, 8'hFF, 8'h5A, 8'h30, 8'h20, 8'h0F, 8'h3A},
    '{1'b1, 8'hC0, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h5A, 8'h3F, 8'h3F, 8'h00, 8'h3F},
    '{1'b1, 8'hFF, 8'h3F, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h0F}};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] p4_in, p5_in;
  logic [7:0] drv [2];
  logic [7:0] ext [2];
  pdc_alt_s p4_alt, p5_alt;
  pdc_pin_s p4_pins, p5_pins, pins;
  int err_total, n_tests, cycles;
  assign hready = hreadyout;
  pdc_port_dir u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .p4_pin_in(p4_in),
    .p5_pin_in(p5_in), .p4_alt(p4_alt), .p5_alt(p5_alt), .p4_pins(p4_pins),
    .p5_pins(p5_pins));
  pdc_board u_b4 (.pins(p4_pins), .drv(drv[0]), .ext(ext[0]), .lvl(p4_in));
  pdc_board u_b5 (.pins(p5_pins), .drv(drv[1]), .ext(ext[1]), .lvl(p5_in));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // a hang counts as a mismatch
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total = err_total + 1;
      results();
    end
  end
  task automatic results();
    $display("errors %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; waits on hready at both phases
  task automatic ahb(input logic w, input logic [19:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {ADDR_TOP_ZERO, idx, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {RDATA_PAD, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [19:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    ahb(1'b1, idx, wd, d);
  endtask
  task automatic rd(input logic [19:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, idx, 8'h00, d);
    cmp(d, exp);
    cmp({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic dir_all();
    for (int i = 0; i < NUM_DIR; i++) rd(DIR_IDX[i], {RDATA_PAD, DIR_RESET});
    for (int i = 0; i < NUM_DIR; i++) wr(DIR_IDX[i], ~DIR_WMASK[i]);
    for (int i = 0; i < NUM_DIR; i++) rd(DIR_IDX[i], {RDATA_PAD, ~DIR_WMASK[i]});
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, cycles, err_total, n_tests} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    drv = '{8'hFF, 8'hFF};
    ext = '{8'h00, 8'h00};
    p4_alt = '{8'hA5, 8'h3C};
    p5_alt = '{8'h00, 8'h00};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ROWS[n]) begin
      drv[ROWS[n].q] <= ROWS[n].drv;
      ext[ROWS[n].q] <= ROWS[n].ext;
      wr(DIR_IDX[DIR_P4 + int'(ROWS[n].q)], ROWS[n].dir);
      wr(OWN_IDX[OWN_DATA4 + int'(ROWS[n].q)], ROWS[n].dat);
      wr(OWN_IDX[OWN_PU4 + int'(ROWS[n].q)], ROWS[n].pu);
      wr(OWN_IDX[OWN_CTRL4 + int'(ROWS[n].q)], ROWS[n].ctl);
      repeat (3) @(posedge hclk);
      pins = ROWS[n].q ? p5_pins : p4_pins;
      cmp({24'h0, pins.oe}, {24'h0, ROWS[n].eo});
      cmp({24'h0, pins.out & pins.oe}, {24'h0, ROWS[n].ev});
      cmp({24'h0, pins.pu}, {24'h0, ROWS[n].ep});
      rd(OWN_IDX[OWN_DATA4 + int'(ROWS[n].q)], {RDATA_PAD, ROWS[n].er});
    end
    // port 5 in control mode: the peripheral owns the low pins, their pull-ups drop
    p5_alt <= '{8'h15, 8'h0F};
    wr(OWN_IDX[OWN_CTRL5], 8'h0F);
    repeat (3) @(posedge hclk);
    cmp({24'h0, p5_pins.oe}, 32'h0000000F);
    cmp({24'h0, p5_pins.out & p5_pins.oe}, 32'h00000005);
    cmp({24'h0, p5_pins.pu}, 32'h00000000);
    rd(OWN_IDX[OWN_DATA5], 32'h00000005);
    wr(OWN_IDX[OWN_CTRL5], 8'h00);
    p5_alt <= '{8'h00, 8'h00};
    // second reset in mid-run, then every direction register
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    cmp({16'h0, p4_pins.oe, p5_pins.oe}, 32'h0);
    dir_all();
    rd(20'hFFF28, 32'h0);
    results();
  end
endmodule
